/* hdl/rx_agc_gain_state_machine.sv */
// Receive gain control state machine with its APB configuration registers
module rx_agc_gain_state_machine (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            rx_enable,
    input  wire logic [15:0]     general_purpose_input,
    input  wire agc_pkg::det_type det,
    output logic      [7:0]      gain_index,
    output logic                 detector_reset,
    output logic                 peak_detector_enable,
    output logic                 controller_holding
);
    agc_pkg::cfg_type   sw_r;
    agc_pkg::cfg_type   act_r;
    agc_pkg::cfg_type   clamp_nxt;
    agc_pkg::state_type state_r;
    logic [21:0] dcnt_r;
    logic [6:0]  scnt_r;
    logic [2:0]  tcnt_r;
    logic [6:0]  guard_r;
    logic [4:0]  rearm_r;
    logic [5:0]  hold_r;
    logic [6:0]  us_r;
    logic [7:0]  gain_r;
    logic [7:0]  gain_nxt;
    logic        holding_r;
    logic        pend_r;
    logic        chg_r;
    logic        det_rst_r;
    logic [1:0]  rx_sync_r;
    logic        rx_prev_r;
    logic [15:0] gpi_meta_r;
    logic [15:0] gpi_sync_r;
    logic        sync_prev_r;
    logic        rx_on;
    logic        rx_rise;
    logic        run;
    logic        us_tick;
    logic        sync_pulse;
    logic        expire;
    logic        imm_attack;
    logic        defer_req;
    logic        do_dec;
    logic        do_inc;
    logic        chg;
    logic        wr_en;
    logic        addr_ok;
    logic [21:0] period_sel;
    logic [8:0]  down_v;
    logic [8:0]  up_v;

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sync_r  <= 2'h0;
            gpi_meta_r <= 16'h0000;
            gpi_sync_r <= 16'h0000;
        end else begin
            rx_sync_r  <= {rx_sync_r[0], rx_enable};
            gpi_meta_r <= general_purpose_input;
            gpi_sync_r <= gpi_meta_r;
        end
    end

    // Edge history of synchronised levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev_r   <= 1'b0;
            sync_prev_r <= 1'b0;
        end else begin
            rx_prev_r   <= rx_on;
            sync_prev_r <= gpi_sync_r[act_r.sync_sel];
        end
    end

    assign rx_on      = rx_sync_r[1];
    assign rx_rise    = rx_on && !rx_prev_r;
    // No step in the enable cycle: the live settings are still the old ones
    assign run        = rx_on && !holding_r && !rx_rise;
    assign sync_pulse = act_r.sync_en && gpi_sync_r[act_r.sync_sel]
                        && !sync_prev_r;

    // APB decode; zero wait states, unmapped addresses answer an error
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    always_comb begin
        addr_ok = 1'b1;
        case (paddr)
            agc_pkg::ADDR_CTRL, agc_pkg::ADDR_LIMITS, agc_pkg::ADDR_PERIOD,
            agc_pkg::ADDR_TIMING, agc_pkg::ADDR_FAST,
            agc_pkg::ADDR_STATUS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Software shadow registers; only a receive enable makes them live
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_r.upper       <= agc_pkg::UPPER_RESET;
            sw_r.lower       <= agc_pkg::LOWER_RESET;
            sw_r.restart_idx <= agc_pkg::RESTART_RESET;
            sw_r.period      <= agc_pkg::PERIOD_RESET;
            sw_r.fast_period <= agc_pkg::FAST_RESET;
            sw_r.rearm       <= agc_pkg::REARM_RESET;
            sw_r.settle      <= agc_pkg::SETTLE_RESET;
            sw_r.hold_us     <= agc_pkg::HOLD_RESET;
            sw_r.attack      <= agc_pkg::ATTACK_RESET;
            sw_r.mode        <= 1'b1;
            sw_r.block       <= 1'b0;
            sw_r.restart_en  <= 1'b0;
            sw_r.sync_en     <= 1'b0;
            sw_r.fast_en     <= 1'b0;
            sw_r.sync_sel    <= 4'h0;
        end else if (wr_en) begin
            case (paddr)
                agc_pkg::ADDR_CTRL: begin
                    sw_r.mode       <= pwdata[agc_pkg::CTRL_MODE];
                    sw_r.block      <= pwdata[agc_pkg::CTRL_BLOCK];
                    sw_r.attack     <= pwdata[agc_pkg::CTRL_ATTACK +: 2];
                    sw_r.restart_en <= pwdata[agc_pkg::CTRL_RESTART];
                    sw_r.sync_en    <= pwdata[agc_pkg::CTRL_SYNC];
                    sw_r.fast_en    <= pwdata[agc_pkg::CTRL_FAST];
                    sw_r.sync_sel   <= pwdata[agc_pkg::CTRL_SEL +: 4];
                end
                agc_pkg::ADDR_LIMITS: begin
                    sw_r.upper       <= pwdata[agc_pkg::LIM_UPPER +: 8];
                    sw_r.lower       <= pwdata[agc_pkg::LIM_LOWER +: 8];
                    sw_r.restart_idx <= pwdata[agc_pkg::LIM_RESTART +: 8];
                end
                agc_pkg::ADDR_PERIOD: sw_r.period <= pwdata[21:0];
                agc_pkg::ADDR_FAST:   sw_r.fast_period <= pwdata[21:0];
                agc_pkg::ADDR_TIMING: begin
                    sw_r.rearm   <= pwdata[agc_pkg::TIM_REARM +: 5];
                    sw_r.settle  <= pwdata[agc_pkg::TIM_SETTLE +: 7];
                    sw_r.hold_us <= pwdata[agc_pkg::TIM_HOLD +: 6];
                end
                default: ;
            endcase
        end
    end

    // Read data captured in the setup cycle so it leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata <= 32'h00000000;
            case (paddr)
                agc_pkg::ADDR_CTRL: prdata <= {20'h00000, sw_r.sync_sel,
                    1'b0, sw_r.fast_en, sw_r.sync_en, sw_r.restart_en,
                    sw_r.attack, sw_r.block, sw_r.mode};
                agc_pkg::ADDR_LIMITS: prdata <= {8'h00, sw_r.restart_idx,
                    sw_r.lower, sw_r.upper};
                agc_pkg::ADDR_PERIOD: prdata <= {10'h000, sw_r.period};
                agc_pkg::ADDR_FAST:   prdata <= {10'h000, sw_r.fast_period};
                agc_pkg::ADDR_TIMING: prdata <= {10'h000, sw_r.hold_us,
                    1'b0, sw_r.settle, 3'h0, sw_r.rearm};
                agc_pkg::ADDR_STATUS: prdata <= {20'h00000, pend_r,
                    holding_r, state_r, gain_r};
                default: ;
            endcase
        end
    end

    // Clamp the shadow copy to legal bounds; lower kept below upper
    always_comb begin
        clamp_nxt = sw_r;
        if (sw_r.upper < agc_pkg::GAIN_MIN + 8'h01)
            clamp_nxt.upper = agc_pkg::GAIN_MIN + 8'h01;
        if (sw_r.lower < agc_pkg::GAIN_MIN)
            clamp_nxt.lower = agc_pkg::GAIN_MIN;
        if (clamp_nxt.lower >= clamp_nxt.upper)
            clamp_nxt.lower = clamp_nxt.upper - 8'h01;
        if (sw_r.restart_idx < agc_pkg::GAIN_MIN)
            clamp_nxt.restart_idx = agc_pkg::GAIN_MIN;
        // Restart index kept inside the limits it will run under
        if (clamp_nxt.restart_idx > clamp_nxt.upper)
            clamp_nxt.restart_idx = clamp_nxt.upper;
        if (clamp_nxt.restart_idx < clamp_nxt.lower)
            clamp_nxt.restart_idx = clamp_nxt.lower;
        if (sw_r.period == 22'h000000)
            clamp_nxt.period = 22'h000001;
        if (sw_r.fast_period == 22'h000000)
            clamp_nxt.fast_period = 22'h000001;
    end

    // Live configuration taken at each receive enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            act_r <= '0;
        else if (rx_rise)
            act_r <= clamp_nxt;
    end

    // Microsecond enable pulse; runs free, so the first tick may come early
    assign us_tick = (us_r == agc_pkg::US_LAST);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            us_r <= 7'h00;
        else
            us_r <= us_tick ? 7'h00 : us_r + 7'h01;
    end

    // Hold after receive enable, counted in microseconds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            holding_r <= 1'b0;
            hold_r    <= 6'h00;
        end else if (rx_rise) begin
            holding_r <= (clamp_nxt.hold_us != 6'h00);
            hold_r    <= clamp_nxt.hold_us;
        end else if (!rx_on) begin
            holding_r <= 1'b0;
        end else if (holding_r && us_tick) begin
            hold_r <= hold_r - 6'h01;
            if (hold_r == 6'h01)
                holding_r <= 1'b0;
        end
    end

    // Decision period selection and expiry; the guard count after a change blocks leaving
    assign period_sel = act_r.fast_en ? act_r.fast_period : act_r.period;
    assign expire = run && state_r == agc_pkg::ST_COUNT && !sync_pulse
                    && dcnt_r == period_sel - 22'h000001
                    && guard_r == 7'h00;

    // Counter, settle and tail states make up one update period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= agc_pkg::ST_IDLE;
            dcnt_r  <= 22'h000000;
            scnt_r  <= 7'h00;
            tcnt_r  <= 3'h0;
        end else if (!rx_on) begin
            if (act_r.restart_en)
                state_r <= agc_pkg::ST_IDLE;
        end else if (run) begin
            case (state_r)
                agc_pkg::ST_IDLE: begin
                    state_r <= agc_pkg::ST_COUNT;
                    dcnt_r  <= 22'h000000;
                end
                agc_pkg::ST_COUNT: begin
                    if (sync_pulse) begin
                        dcnt_r <= 22'h000000;
                    end else if (expire) begin
                        dcnt_r  <= 22'h000000;
                        scnt_r  <= 7'h00;
                        tcnt_r  <= 3'h0;
                        state_r <= (act_r.settle == 7'h00) ?
                            agc_pkg::ST_TAIL : agc_pkg::ST_SETTLE;
                    end else if (dcnt_r < period_sel - 22'h000001) begin
                        dcnt_r <= dcnt_r + 22'h000001;
                    end
                end
                agc_pkg::ST_SETTLE: begin
                    scnt_r <= scnt_r + 7'h01;
                    if (scnt_r == act_r.settle - 7'h01)
                        state_r <= agc_pkg::ST_TAIL;
                end
                agc_pkg::ST_TAIL: begin
                    tcnt_r <= tcnt_r + 3'h1;
                    if (tcnt_r == agc_pkg::TAIL_LAST)
                        state_r <= agc_pkg::ST_COUNT;
                end
                default: state_r <= agc_pkg::ST_IDLE;
            endcase
        end
    end

    // Peak attack timing: bit 0 half-band, bit 1 analog peak immediate
    assign imm_attack = run && state_r == agc_pkg::ST_COUNT
        && guard_r == 7'h00 && rearm_r == 5'h00
        && ((det.hb_high && act_r.attack[0])
        ||  (det.apd_high && act_r.attack[1]));
    assign defer_req = run && rearm_r == 5'h00
        && ((det.hb_high && !act_r.attack[0])
        ||  (det.apd_high && !act_r.attack[1]));
    assign do_dec = pend_r || defer_req
        || (!act_r.mode && det.power_dec);
    assign do_inc = act_r.mode ? det.peak_inc
        : (det.power_inc && !(act_r.block
        && (det.apd_low || det.hb_low)));

    // Deferred attack memory; the clearing expiry wins over a new request in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pend_r <= 1'b0;
        else if (defer_req && !expire)
            pend_r <= 1'b1;
        else if (expire)
            pend_r <= 1'b0;
    end

    // Step the index, clipped to the live limits
    assign down_v = {1'b0, gain_r} - {4'h0, det.dec_step};
    assign up_v   = {1'b0, gain_r} + {4'h0, det.inc_step};
    always_comb begin
        gain_nxt = gain_r;
        chg      = 1'b0;
        if (imm_attack || (expire && do_dec)) begin
            chg = 1'b1;
            if (down_v[8] || down_v[7:0] < act_r.lower)
                gain_nxt = act_r.lower;
            else
                gain_nxt = down_v[7:0];
        end else if (expire && do_inc) begin
            chg = 1'b1;
            if (up_v > {1'b0, act_r.upper})
                gain_nxt = act_r.upper;
            else
                gain_nxt = up_v[7:0];
        end
    end

    // Gain index; restart or limits applied at receive enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_r <= agc_pkg::GAIN_MAX;
        end else if (rx_rise) begin
            if (clamp_nxt.restart_en && state_r == agc_pkg::ST_IDLE)
                gain_r <= clamp_nxt.restart_idx;
            else if (gain_r > clamp_nxt.upper)
                gain_r <= clamp_nxt.upper;
            else if (gain_r < clamp_nxt.lower)
                gain_r <= clamp_nxt.lower;
        end else if (run) begin
            gain_r <= gain_nxt;
        end
    end

    // Change spacing and peak re-arm after every change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guard_r   <= 7'h00;
            rearm_r   <= 5'h00;
            chg_r     <= 1'b0;
            det_rst_r <= 1'b0;
        end else begin
            chg_r     <= chg;
            det_rst_r <= expire;
            if (chg) begin
                guard_r <= act_r.settle;
                rearm_r <= act_r.rearm;
            end else if (run) begin
                if (guard_r != 7'h00)
                    guard_r <= guard_r - 7'h01;
                if (rearm_r != 5'h00)
                    rearm_r <= rearm_r - 5'h01;
            end
        end
    end

    assign gain_index           = gain_r;
    assign detector_reset       = det_rst_r;
    assign peak_detector_enable = run && rearm_r == 5'h00;
    assign controller_holding   = holding_r;

    property p_upper;
        @(posedge pclk) disable iff (!presetn)
        run |-> gain_r <= act_r.upper;
    endproperty
    a_upper: assert property (p_upper) else $error("gain above upper");

    property p_lower;
        @(posedge pclk) disable iff (!presetn)
        run |-> gain_r >= act_r.lower;
    endproperty
    a_lower: assert property (p_lower) else $error("gain below lower");

    property p_rearm;
        @(posedge pclk) disable iff (!presetn)
        (chg_r && act_r.rearm != 5'h00) |-> !peak_detector_enable;
    endproperty
    a_rearm: assert property (p_rearm) else $error("peaks not off");

    property p_guard;
        @(posedge pclk) disable iff (!presetn)
        (chg_r && act_r.settle != 7'h00) |-> !imm_attack;
    endproperty
    a_guard: assert property (p_guard) else $error("change too soon");

    property p_detrst;
        @(posedge pclk) disable iff (!presetn)
        expire |=> detector_reset ##1 !detector_reset;
    endproperty
    a_detrst: assert property (p_detrst) else $error("no detector reset");

    property p_tail;
        @(posedge pclk) disable iff (!presetn)
        (state_r == agc_pkg::ST_TAIL && tcnt_r == 3'h0 && run)
        ##1 run [*4] |=> state_r == agc_pkg::ST_COUNT;
    endproperty
    a_tail: assert property (p_tail) else $error("tail not five");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (rx_rise && clamp_nxt.hold_us != 6'h00) |=> holding_r && !run;
    endproperty
    a_hold: assert property (p_hold) else $error("no hold at enable");

    property p_block;
        @(posedge pclk) disable iff (!presetn)
        (expire && !act_r.mode && act_r.block && (det.apd_low || det.hb_low)
         && !do_dec && !imm_attack) |=> gain_r == $past(gain_r);
    endproperty
    a_block: assert property (p_block) else $error("blocked rise");

    property p_mode;
        @(posedge pclk) disable iff (!presetn)
        (expire && act_r.mode && !det.peak_inc && !pend_r && !defer_req
         && !imm_attack) |=> gain_r == $past(gain_r);
    endproperty
    a_mode: assert property (p_mode) else $error("power used");

    property p_keep;
        @(posedge pclk) disable iff (!presetn)
        (!rx_on && !act_r.restart_en) |=> $stable(state_r);
    endproperty
    a_keep: assert property (p_keep) else $error("state lost");
endmodule

/* hdl/agc_pkg.sv */
// Constants, register map and carrier types of the receive gain controller
package agc_pkg;
    // Register byte offsets on the 32-bit bus
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LIMITS = 8'h04;
    localparam logic [7:0] ADDR_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_TIMING = 8'h0C;
    localparam logic [7:0] ADDR_FAST   = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // Control register fields
    localparam int CTRL_MODE    = 0;
    localparam int CTRL_BLOCK   = 1;
    localparam int CTRL_ATTACK  = 2;
    localparam int CTRL_RESTART = 4;
    localparam int CTRL_SYNC    = 5;
    localparam int CTRL_FAST    = 6;
    localparam int CTRL_SEL     = 8;
    // Limits and timing register fields
    localparam int LIM_UPPER    = 0;
    localparam int LIM_LOWER    = 8;
    localparam int LIM_RESTART  = 16;
    localparam int TIM_REARM    = 0;
    localparam int TIM_SETTLE   = 8;
    localparam int TIM_HOLD     = 16;
    // Legal bounds and reset values
    localparam logic [7:0]  GAIN_MIN        = 8'hC3;
    localparam logic [7:0]  GAIN_MAX        = 8'hFF;
    localparam logic [7:0]  UPPER_RESET     = 8'hFF;
    localparam logic [7:0]  LOWER_RESET     = 8'hC3;
    localparam logic [7:0]  RESTART_RESET   = 8'hFF;
    localparam logic [4:0]  REARM_RESET     = 5'h04;
    localparam logic [6:0]  SETTLE_RESET    = 7'h10;
    localparam logic [5:0]  HOLD_RESET      = 6'h0A;
    localparam logic [21:0] PERIOD_RESET    = 22'h002D00;
    localparam logic [21:0] FAST_RESET      = 22'h002D00;
    localparam logic [1:0]  ATTACK_RESET    = 2'h3;
    // Timing: tail state length and microsecond divider
    localparam logic [2:0]  TAIL_LAST       = 3'h4;
    localparam int          US_NS           = 1000;
    localparam int          CLK_NS          = 8;
    localparam int          CYCLES_PER_US   = (US_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0]  US_LAST = 7'(CYCLES_PER_US - 1);

    // Sampled configuration
    typedef struct packed {
        logic [7:0]  upper;
        logic [7:0]  lower;
        logic [7:0]  restart_idx;
        logic [21:0] period;
        logic [21:0] fast_period;
        logic [4:0]  rearm;
        logic [6:0]  settle;
        logic [5:0]  hold_us;
        logic [1:0]  attack;
        logic        mode;
        logic        block;
        logic        restart_en;
        logic        sync_en;
        logic        fast_en;
        logic [3:0]  sync_sel;
    } cfg_type;

    // Detector requests, same clock domain
    typedef struct packed {
        logic       apd_high;
        logic       hb_high;
        logic       apd_low;
        logic       hb_low;
        logic       peak_inc;
        logic       power_inc;
        logic       power_dec;
        logic [4:0] inc_step;
        logic [4:0] dec_step;
    } det_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_COUNT  = 2'b01,
        ST_SETTLE = 2'b11,
        ST_TAIL   = 2'b10
    } state_type;
endpackage

/* tb/test_rx_agc_gain_state_machine.sv */
// Self-checking bench for the receive gain controller over its APB port
module test_rx_agc_gain_state_machine;
    timeunit 1ns;
    timeprecision 100ps;

    logic             pclk                  = 1'b0;
    logic             presetn               = 1'b0;
    logic             psel                  = 1'b0;
    logic             penable               = 1'b0;
    logic             pwrite                = 1'b0;
    logic [7:0]       paddr                 = 8'h00;
    logic [31:0]      pwdata                = 32'h0;
    logic             rx_enable             = 1'b0;
    logic [15:0]      general_purpose_input = 16'h0000;
    agc_pkg::det_type det                   = '0;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [7:0]       gain_index;
    logic             detector_reset;
    logic             peak_detector_enable;
    logic             controller_holding;
    logic [31:0]      rd;
    logic             er;
    int               errors                = 0;
    int               total_checks          = 0;
    int               n;
    // Register reset values, offsets 0x00 to 0x10
    logic [31:0]      rst_val [5] = '{32'h0000000D, 32'h00FFC3FF,
        32'h00002D00, 32'h000A1004, 32'h00002D00};

    rx_agc_gain_state_machine i_rx_agc_gain_state_machine (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_enable(rx_enable),
        .general_purpose_input(general_purpose_input), .det(det),
        .gain_index(gain_index), .detector_reset(detector_reset),
        .peak_detector_enable(peak_detector_enable),
        .controller_holding(controller_holding));

    // Free-running 125 MHz clock
    always #4 pclk = ~pclk;

    task automatic final_report;
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; an idle cycle follows so no signal is set twice
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            errors++;
            final_report;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Cycles until the next detector reset pulse, sampled when settled
    task automatic wait_pulse(output int cnt);
        cnt = 0;
        do begin
            @(negedge pclk);
            cnt++;
        end while (detector_reset !== 1'b1 && cnt < 300);
        if (cnt >= 300) begin
            errors++;
            final_report;
        end
    endtask

    // Half-band high request held for len sampling edges
    task automatic attack(input logic [4:0] step, input int len);
        @(posedge pclk);
        det.hb_high  <= 1'b1;
        det.dec_step <= step;
        repeat (len) @(posedge pclk);
        det.hb_high  <= 1'b0;
        @(negedge pclk);
    endtask

    // Receive off then on; new settings go live at the rising enable
    task automatic rx_on(input logic [7:0] exp_gain);
        @(posedge pclk);
        rx_enable <= 1'b0;
        repeat (10) @(posedge pclk);
        rx_enable <= 1'b1;
        repeat (6) @(negedge pclk);
        chk(32'(controller_holding), 32'h1);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (controller_holding !== 1'b0 && n < 400);
        chk(32'(n > 100 && n < 400), 32'h1);
        if (n >= 400)
            final_report;
        chk(32'(gain_index), 32'(exp_gain));
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        chk(32'(gain_index), 32'h000000FF);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, rst_val[i]);
        end
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b1, agc_pkg::ADDR_LIMITS, 32'h00FFE0F0);
        apb(1'b1, agc_pkg::ADDR_PERIOD, 32'h00000014);
        apb(1'b1, agc_pkg::ADDR_TIMING, 32'h00020203);
        rx_on(8'hF0);
        wait_pulse(n);
        wait_pulse(n);
        chk(32'(n), 32'd27);
        repeat (9) @(negedge pclk);
        attack(5'h05, 2);
        chk(32'(gain_index), 32'h000000EB);
        chk(32'(peak_detector_enable), 32'h0);
        repeat (6) @(negedge pclk);
        chk(32'(peak_detector_enable), 32'h1);
        attack(5'h1F, 1);
        chk(32'(gain_index), 32'h000000E0);
        // Peak recovery only lands at the decision expiry, capped
        wait_pulse(n);
        @(posedge pclk);
        det.peak_inc <= 1'b1;
        det.inc_step <= 5'h1F;
        repeat (4) @(negedge pclk);
        chk(32'(gain_index), 32'h000000E0);
        wait_pulse(n);
        chk(32'(gain_index), 32'h000000F0);
        @(posedge pclk);
        det.peak_inc <= 1'b0;
        apb(1'b1, agc_pkg::ADDR_CTRL, 32'h00000001);
        rx_on(8'hF0);
        wait_pulse(n);
        repeat (9) @(negedge pclk);
        attack(5'h05, 1);
        chk(32'(gain_index), 32'h000000F0);
        wait_pulse(n);
        chk(32'(gain_index), 32'h000000EB);
        apb(1'b1, agc_pkg::ADDR_LIMITS, 32'h00E8E0F0);
        apb(1'b1, agc_pkg::ADDR_CTRL, 32'h00000011);
        // Restart bit goes live at this enable, so the gain is kept once more
        rx_on(8'hEB);
        apb(1'b1, agc_pkg::ADDR_CTRL, 32'h00000331);
        rx_on(8'hE8);
        // Sync pulse on input 3 restarts the decision count
        wait_pulse(n);
        repeat (9) @(negedge pclk);
        @(posedge pclk);
        general_purpose_input <= 16'h0008;
        @(posedge pclk);
        general_purpose_input <= 16'h0000;
        wait_pulse(n);
        chk(32'(n), 32'd23);
        // Power mode with increase blocking and the short interval
        apb(1'b1, agc_pkg::ADDR_FAST, 32'h0000000A);
        apb(1'b1, agc_pkg::ADDR_CTRL, 32'h0000004E);
        rx_on(8'hE8);
        @(posedge pclk);
        det.power_inc <= 1'b1;
        det.hb_low    <= 1'b1;
        wait_pulse(n);
        wait_pulse(n);
        chk(32'(n), 32'd17);
        chk(32'(gain_index), 32'h000000E8);
        @(posedge pclk);
        det.hb_low <= 1'b0;
        wait_pulse(n);
        chk(32'(gain_index), 32'h000000F0);
        final_report;
    end
endmodule
